/* File: verilog/address_space_select_check.sv */
// address space tag selection, privilege check and context mapping
// assumes a pipeline issuing one request per cycle on CORE_CLK, same domain
`timescale 1ns/100ps
`include "asel_params.svh"
module address_space_select_check
  import asel_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // processor state
  input wire logic PRIVILEGE_MODE_FLAG,
  input wire logic DEFAULT_LITTLE_ENDIAN_FLAG,
  input wire logic [`TL_W-1:0] TRAP_LEVEL,
  input wire logic [`TAG_W-1:0] TAG_REGISTER,
  input wire logic [`CTX_ID_W-1:0] PRIMARY_CTX,
  input wire logic [`CTX_ID_W-1:0] SECONDARY_CTX,
  // request from issue
  input wire logic REQ_VALID,
  input wire logic [1:0] REQ_KIND,
  input wire logic REQ_ALTERNATE,
  input wire logic REQ_REG_REG,
  input wire logic [`TAG_W-1:0] REQ_INSN_TAG,
  input wire logic [`OFFSET_W-1:0] REQ_OFFSET,
  input wire logic [7:0] REQ_ID,
  // forwarded access to memory management
  output logic MEM_VALID,
  output logic [1:0] MEM_KIND,
  output logic [`TAG_W-1:0] ADDRESS_SPACE_TAG,
  output logic [`OFFSET_W-1:0] MEM_OFFSET,
  output logic [1:0] MEM_CTX_SEL,
  output logic [`CTX_ID_W-1:0] MEM_CTX_ID,
  output logic [7:0] MEM_ID,
  // privilege trap report
  output logic TRAP_VALID,
  output logic [`TAG_W-1:0] TRAP_TAG,
  output logic [7:0] TRAP_ID
);

  // allowed check for a tag under the current mode
  function automatic logic tag_allowed(input tag_t t, input logic priv);
    logic ok;
    ok = 1'b1;
    if (!priv && !t[7]) begin
      ok = 1'b0;
    end else if (priv && t >= `FORBID_LO_CODE && t <= `FORBID_HI_CODE) begin
      ok = 1'b0;
    end
    return ok;
  endfunction : tag_allowed

  // context for a tag
  function automatic ctx_sel_e tag_ctx(input tag_t t);
    ctx_sel_e c;
    c = CTX_NONE;
    if (t == `PRIMARY_SPACE_CODE || t == `PRIMARY_SPACE_LE_CODE) begin
      c = CTX_PRIMARY;
    end else if (t == `SECONDARY_SPACE_CODE || t == `SECONDARY_SPACE_LE_CODE) begin
      c = CTX_SECONDARY;
    end else if (t == `KERNEL_SPACE_CODE || t == `KERNEL_SPACE_LE_CODE) begin
      c = CTX_KERNEL;
    end
    return c;
  endfunction : tag_ctx

  // implicit tag from processor state
  function automatic tag_t implicit_tag(input logic [1:0] kind, input logic priv,
      input logic le, input logic [`TL_W-1:0] tl);
    tag_t t;
    t = `PRIMARY_SPACE_CODE;
    if (tl == '0) begin
      if (kind != `ACC_FETCH && le) begin
        t = `PRIMARY_SPACE_LE_CODE;
      end else begin
        t = `PRIMARY_SPACE_CODE;
      end
    end else if (kind == `ACC_FETCH) begin
      if (priv) begin
        t = `KERNEL_SPACE_CODE;
      end else begin
        t = `PRIMARY_SPACE_CODE;
      end
    end else if (le) begin
      t = `KERNEL_SPACE_LE_CODE;
    end else begin
      t = `KERNEL_SPACE_CODE;
    end
    return t;
  endfunction : implicit_tag

  tag_t tag_d;
  logic use_explicit_d;
  logic ok_d;
  logic fwd_d;
  logic trap_d;
  ctx_sel_e ctx_d;
  ctx_id_t ctx_id_d;

  // explicit tag applies to data accesses only
  always_comb begin
    use_explicit_d = REQ_ALTERNATE && (REQ_KIND != `ACC_FETCH);
  end

  // tag selection
  always_comb begin
    tag_d = implicit_tag(REQ_KIND, PRIVILEGE_MODE_FLAG, DEFAULT_LITTLE_ENDIAN_FLAG, TRAP_LEVEL);
    if (use_explicit_d) begin
      if (REQ_REG_REG) begin
        tag_d = REQ_INSN_TAG;
      end else begin
        tag_d = TAG_REGISTER;
      end
    end
  end

  // privilege check
  always_comb begin
    ok_d = tag_allowed(tag_d, PRIVILEGE_MODE_FLAG);
    fwd_d = REQ_VALID && ok_d;
    trap_d = REQ_VALID && !ok_d;
  end

  // context lookup
  always_comb begin
    ctx_d = tag_ctx(tag_d);
    case (ctx_d)
      CTX_PRIMARY: ctx_id_d = PRIMARY_CTX;
      CTX_SECONDARY: ctx_id_d = SECONDARY_CTX;
      default: ctx_id_d = '0;
    endcase
  end

  // forwarded access strobe
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      MEM_VALID <= 1'b0;
    end else begin
      MEM_VALID <= fwd_d;
    end
  end

  // forwarded access kind
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      MEM_KIND <= 2'h0;
    end else if (fwd_d) begin
      MEM_KIND <= REQ_KIND;
    end
  end

  // forwarded address space tag
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ADDRESS_SPACE_TAG <= 8'h00;
    end else if (fwd_d) begin
      ADDRESS_SPACE_TAG <= tag_d;
    end
  end

  // forwarded byte offset
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      MEM_OFFSET <= 64'h0;
    end else if (fwd_d) begin
      MEM_OFFSET <= REQ_OFFSET;
    end
  end

  // forwarded context select
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      MEM_CTX_SEL <= 2'h0;
    end else if (fwd_d) begin
      MEM_CTX_SEL <= 2'(ctx_d);
    end
  end

  // forwarded context id
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      MEM_CTX_ID <= '0;
    end else if (fwd_d) begin
      MEM_CTX_ID <= ctx_id_d;
    end
  end

  // forwarded instruction id
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      MEM_ID <= 8'h00;
    end else if (fwd_d) begin
      MEM_ID <= REQ_ID;
    end
  end

  // trap strobe
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      TRAP_VALID <= 1'b0;
    end else begin
      TRAP_VALID <= trap_d;
    end
  end

  // trapped tag
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      TRAP_TAG <= 8'h00;
    end else if (trap_d) begin
      TRAP_TAG <= tag_d;
    end
  end

  // trapped instruction id
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      TRAP_ID <= 8'h00;
    end else if (trap_d) begin
      TRAP_ID <= REQ_ID;
    end
  end

endmodule : address_space_select_check

/* File: verilog/asel_params.svh */
// constants for the address space select and check block
// assumes inclusion by the package and the design file
`ifndef ASEL_PARAMS_SVH
`define ASEL_PARAMS_SVH
`define TAG_W 8
`define OFFSET_W 64
`define CTX_ID_W 13
`define TL_W 3
`define PRIMARY_SPACE_CODE 8'h80
`define SECONDARY_SPACE_CODE 8'h81
`define PRIMARY_SPACE_LE_CODE 8'h88
`define SECONDARY_SPACE_LE_CODE 8'h89
`define KERNEL_SPACE_CODE 8'h04
`define KERNEL_SPACE_LE_CODE 8'h0c
`define RESTRICT_TOP_CODE 8'h2f
`define FORBID_LO_CODE 8'h30
`define FORBID_HI_CODE 8'h7f
`define MAX_PRIV_TL 3'h2
`define ACC_FETCH 2'h0
`define ACC_LOAD 2'h1
`define ACC_STORE 2'h2
`define ACC_PREFETCH 2'h3
`endif

/* File: verilog/asel_pkg.sv */
// types for the address space select and check block
// assumes asel_params.svh is on the include path
`include "asel_params.svh"
package asel_pkg;
  typedef logic [`TAG_W-1:0] tag_t;
  typedef logic [`OFFSET_W-1:0] offset_t;
  typedef logic [`CTX_ID_W-1:0] ctx_id_t;
  typedef enum logic [1:0] {CTX_PRIMARY, CTX_SECONDARY, CTX_KERNEL, CTX_NONE} ctx_sel_e;
endpackage : asel_pkg

/* File: tb/mmu_model.sv */
// far side model: counts the accesses it takes
// assumes the select block clock
`timescale 1ns/100ps
module mmu_model (
  input wire logic clk,
  input wire logic v,
  output int taken
);
  always @(posedge clk) if (v) taken <= taken + 1;
endmodule : mmu_model

/* File: tb/asel_chk.sv */
// checker for the tag select block
// assumes a bind onto its top module
`timescale 1ns/100ps
module asel_chk (
  input wire logic CORE_CLK, RST, PRIVILEGE_MODE_FLAG, DEFAULT_LITTLE_ENDIAN_FLAG,
  input wire logic REQ_VALID, REQ_ALTERNATE, MEM_VALID, TRAP_VALID,
  input wire logic [2:0] TRAP_LEVEL,
  input wire logic [1:0] REQ_KIND,
  input wire logic [7:0] ADDRESS_SPACE_TAG, TRAP_TAG
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  sequence dreq; REQ_VALID && REQ_KIND != 2'h0; endsequence
  sequence kreq; dreq ##0 PRIVILEGE_MODE_FLAG && !REQ_ALTERNATE && TRAP_LEVEL inside {1, 2};
  endsequence
  AST_ONE: assert property (REQ_VALID |=> MEM_VALID != TRAP_VALID)
    else $error("no single answer");
  AST_IDLE: assert property (!REQ_VALID |=> !MEM_VALID && !TRAP_VALID)
    else $error("spurious answer");
  AST_NP: assert property (MEM_VALID |-> ADDRESS_SPACE_TAG[7] || $past(PRIVILEGE_MODE_FLAG))
    else $error("restricted tag passed");
  AST_GAP: assert property (MEM_VALID |-> !(ADDRESS_SPACE_TAG inside {[8'h30:8'h7f]}))
    else $error("forbidden tag passed");
  AST_OPEN: assert property (TRAP_VALID |-> !TRAP_TAG[7])
    else $error("open tag trapped");
  AST_PRIV: assert property (TRAP_VALID && $past(PRIVILEGE_MODE_FLAG) |-> TRAP_TAG > 8'h2f)
    else $error("privileged trap on valid tag");
  AST_FETCH: assert property (REQ_VALID && REQ_KIND == 2'h0 && TRAP_LEVEL == 3'h0 |=>
    ADDRESS_SPACE_TAG == 8'h80) else $error("fetch tag");
  AST_KERN: assert property (kreq |=> ADDRESS_SPACE_TAG ==
    ($past(DEFAULT_LITTLE_ENDIAN_FLAG) ? 8'h0c : 8'h04)) else $error("kernel tag");
endmodule : asel_chk
bind address_space_select_check asel_chk i_asel_chk (.*);

/* File: tb/testbench.sv */
// bench for the tag select block
// assumes design, checker and model compiled first
`timescale 1ns/100ps
module testbench;
  logic CORE_CLK = 0, RST = 1, PRIVILEGE_MODE_FLAG = 0, DEFAULT_LITTLE_ENDIAN_FLAG = 0;
  logic REQ_VALID = 0, REQ_ALTERNATE = 0, REQ_REG_REG = 0, MEM_VALID, TRAP_VALID;
  logic [2:0] TRAP_LEVEL = 0;
  logic [1:0] REQ_KIND = 0, MEM_KIND, MEM_CTX_SEL;
  logic [7:0] TAG_REGISTER = 0, REQ_INSN_TAG = 0, REQ_ID = 0, ADDRESS_SPACE_TAG, MEM_ID;
  logic [7:0] TRAP_TAG, TRAP_ID;
  logic [12:0] PRIMARY_CTX = 1, SECONDARY_CTX = 2, MEM_CTX_ID;
  logic [63:0] REQ_OFFSET = 0, MEM_OFFSET;
  int n_fail, check_count, taken, n_mem, n_req;
  always #50 CORE_CLK = ~CORE_CLK;
  address_space_select_check i_address_space_select_check (.*);
  mmu_model i_mmu_model (.clk(CORE_CLK), .v(MEM_VALID), .taken(taken));
  task chk(input string n, input logic [63:0] s, e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task conclude;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // one request: mode, endian, alternate, reg+reg, level, kind, tag given, tag expected
  task t(input logic p, c, a, r, input logic [2:0] l, input logic [1:0] k,
      input logic [7:0] g, x);
    logic tr;
    logic [1:0] cs;
    logic [12:0] ci;
    tr = p ? x inside {[8'h30:8'h7f]} : !x[7];
    cs = (x == 8'h80 || x == 8'h88) ? 2'h0 : (x == 8'h81 || x == 8'h89) ? 2'h1 :
        (x == 8'h04 || x == 8'h0c) ? 2'h2 : 2'h3;
    ci = cs == 2'h0 ? PRIMARY_CTX : cs == 2'h1 ? SECONDARY_CTX : 13'h0;
    n_req++;
    @(posedge CORE_CLK);
    REQ_ID <= 8'(n_req);
    REQ_OFFSET <= 64'hc0de_0000_0000_0000 + 64'(n_req);
    PRIVILEGE_MODE_FLAG <= p;
    DEFAULT_LITTLE_ENDIAN_FLAG <= c;
    REQ_ALTERNATE <= a;
    REQ_REG_REG <= r;
    TRAP_LEVEL <= l;
    REQ_KIND <= k;
    TAG_REGISTER <= r ? ~g : g;
    REQ_INSN_TAG <= r ? g : ~g;
    REQ_VALID <= 1;
    @(posedge CORE_CLK);
    REQ_VALID <= 0;
    #1;
    n_mem += !tr;
    chk("fwd", MEM_VALID, !tr);
    chk("tag", tr ? TRAP_TAG : ADDRESS_SPACE_TAG, x);
    chk("trap", TRAP_VALID, tr);
    chk("id", tr ? TRAP_ID : MEM_ID, 8'(n_req));
    if (!tr) begin
      chk("kind", MEM_KIND, k);
      chk("offset", MEM_OFFSET, 64'hc0de_0000_0000_0000 + 64'(n_req));
      chk("ctx sel", MEM_CTX_SEL, cs);
      chk("ctx id", MEM_CTX_ID, ci);
    end
  endtask : t
  initial begin
    repeat (3) @(posedge CORE_CLK);
    RST <= 0;
    t(0, 1, 0, 0, 0, 1, 0, 'h88);
    t(0, 1, 0, 0, 0, 0, 0, 'h80);
    t(1, 1, 0, 0, 1, 0, 0, 'h04);
    t(1, 1, 0, 0, 1, 3, 0, 'h0c);
    t(1, 0, 1, 1, 0, 1, 'h2f, 'h2f);
    t(0, 0, 1, 1, 0, 2, 'h10, 'h10);
    t(1, 0, 1, 0, 0, 1, 'h30, 'h30);
    t(0, 1, 1, 0, 0, 1, 'h81, 'h81);
    t(0, 0, 1, 0, 0, 2, 'h89, 'h89);
    t(0, 1, 0, 0, 2, 1, 0, 'h0c);
    t(0, 0, 0, 0, 1, 0, 0, 'h80);
    t(1, 0, 0, 0, 2, 2, 0, 'h04);
    t(1, 0, 1, 1, 1, 0, 'h30, 'h04);
    @(posedge CORE_CLK);
    #1;
    chk("count", taken, n_mem);
    @(posedge CORE_CLK);
    RST <= 1;
    repeat (2) @(posedge CORE_CLK);
    #1;
    chk("rst tag", ADDRESS_SPACE_TAG, 8'h00);
    chk("rst trap id", TRAP_ID, 8'h00);
    @(posedge CORE_CLK);
    RST <= 0;
    t(0, 0, 1, 1, 0, 1, 'h81, 'h81);
    conclude;
  end
  initial begin
    #20000;
    n_fail++;
    conclude;
  end
endmodule : testbench
